// ### hdl/cmp_pkg.sv
package cmp_pkg;
  localparam int CNT_W = 32;
  localparam int CLK_HZ = 200000000;
  localparam int BASE_HZ = 1000000;
  localparam int BASE_DIV = CLK_HZ / BASE_HZ;
  localparam int OUT_MAX_HZ = 40000;
  localparam int OUT_MIN_CYC = (CLK_HZ + 2 * OUT_MAX_HZ - 1) / (2 * OUT_MAX_HZ);
  localparam int BIN_DIV = 16;
  localparam int BCD_DIV = 10;
  localparam int MODE_DEC_BIT = 15;
  localparam int MODE_SRC_LO = 4;
  localparam int MODE_DIV5_LO = 8;
  localparam logic [2:0] OSEL_HIGH_GE = 3'h0;
  localparam logic [2:0] OSEL_HIGH_LT = 3'h4;
  localparam logic [2:0] OSEL_PULSE_HI = 3'h1;
  localparam logic [2:0] OSEL_PULSE_LO = 3'h5;
  localparam int NUM_SW = 3;
  localparam int NUM_CYC = 2;
endpackage : cmp_pkg

// ### hdl/scaler_stage.sv
`timescale 1ns/1ps
module scaler_stage
  import cmp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic [15:0] div_i,
  output logic tick_o
);
  logic [15:0] cnt_r, cnt_nxt;
  logic tick_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (tick_i) begin
      if (cnt_r + 16'h1 >= div_i || div_i == 16'h0) begin
        cnt_nxt = 16'h0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h1;
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 16'h0;
      tick_o <= 1'b0;
    end else if (en_i) begin
      cnt_r <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end
endmodule : scaler_stage

// ### hdl/out_shaper.sv
`timescale 1ns/1ps
module out_shaper
  import cmp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic sample_i,
  input wire logic [2:0] osel_i,
  input wire logic invert_i,
  input wire logic [CNT_W-1:0] count_i,
  input wire logic [CNT_W-1:0] threshold_i,
  input wire logic [15:0] pulse_len_i,
  input wire logic pulse_tick_i,
  output logic level_o
);
  logic [15:0] pcnt_r, pcnt_nxt;
  logic raw_r, raw_nxt;
  logic hit_r, hit_nxt;
  logic signed [CNT_W-1:0] cs, ts;
  always_comb begin
    cs = $signed(count_i);
    ts = $signed(threshold_i);
    pcnt_nxt = pcnt_r;
    raw_nxt = raw_r;
    hit_nxt = hit_r;
    if (pcnt_r != 16'h0 && pulse_tick_i) begin
      pcnt_nxt = pcnt_r - 16'h1;
    end
    if (sample_i) begin
      hit_nxt = (cs == ts);
      // level forms follow the signed compare; wrap flips it silently
      case (osel_i)
        OSEL_HIGH_GE: raw_nxt = ts[CNT_W-1] ? (cs <= ts) : (cs >= ts);
        OSEL_HIGH_LT: raw_nxt = ts[CNT_W-1] ? (cs > ts) : (cs < ts);
        default: begin
          if (cs == ts && !hit_r) begin
            pcnt_nxt = pulse_len_i;
          end
          raw_nxt = (pcnt_nxt != 16'h0) ^ (osel_i == OSEL_PULSE_LO);
        end
      endcase
    end else if (osel_i == OSEL_PULSE_HI || osel_i == OSEL_PULSE_LO) begin
      raw_nxt = (pcnt_nxt != 16'h0) ^ (osel_i == OSEL_PULSE_LO);
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pcnt_r <= 16'h0;
      raw_r <= 1'b0;
      hit_r <= 1'b0;
      level_o <= 1'b0;
    end else if (en_i) begin
      pcnt_r <= pcnt_nxt;
      raw_r <= raw_nxt;
      hit_r <= hit_nxt;
      level_o <= raw_nxt ^ invert_i;
    end
  end
endmodule : out_shaper

// ### hdl/counter_compare_refclock.sv
`timescale 1ns/1ps
// Contract
// - counters 3-5 outputs may be inverted
// - counters 3-5 offer programmable length pulse
// - counters 6-7 compared only when idle
// - positive 000: high at or above threshold
// - positive 100: high below threshold
// - level forms flip at wrap silently
// - 001: high pulse at threshold match
// - 101: low pulse at threshold match
// - pulse forms ignore wrap
// - negative 000: high at or below threshold
// - negative 100: high above threshold
// - 1 MHz divided by prescaler gives clock one
// - four stages divide by 16 or 10
// - stage outputs give reference clocks two-five
// - mode bits 4-7 pick fifth scaler source
// - fifth scaler divides 1-16 by bits 8-11
// - sixth clock routable to gates one-five
// - one scaler chain shared by all
// - outputs limited to 40 kHz, except a high level that a disable drops
// - pulse length from pulse duration register
// - counters 6-7 enabled by own mode bit
// - outputs off until enable command
module counter_compare_refclock
  import cmp_pkg::*;
#(
  parameter int NUM_GATES = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [15:0] global_mode_register_i,
  input wire logic [15:0] prescaler_i,
  input wire logic [15:0] pulse_duration_i,
  input wire logic output_enable_cmd_i,
  input wire logic output_disable_cmd_i,
  input wire logic busy_i,
  input wire logic [NUM_SW-1:0] sw_cmp_en_i,
  input wire logic [NUM_SW-1:0] sw_invert_i,
  input wire logic [NUM_SW*3-1:0] sw_osel_i,
  input wire logic [NUM_SW*CNT_W-1:0] sw_count_i,
  input wire logic [NUM_SW*CNT_W-1:0] sw_threshold_i,
  input wire logic [NUM_CYC-1:0] cyc_cmp_en_i,
  input wire logic [NUM_CYC*3-1:0] cyc_osel_i,
  input wire logic [NUM_CYC*CNT_W-1:0] cyc_count_i,
  input wire logic [NUM_CYC*CNT_W-1:0] cyc_threshold_i,
  input wire logic [NUM_GATES-1:0] gate_sel_i,
  output logic [4:0] ref_clk_o,
  output logic ref_clk_gate_select_o,
  output logic [NUM_GATES-1:0] gate_o,
  output logic [NUM_SW+NUM_CYC-1:0] out_o
);
  localparam int NOUT = NUM_SW + NUM_CYC;
  initial begin
    if (NUM_GATES < 1 || NUM_GATES > 5) $error("NUM_GATES must be 1 to 5");
  end

  // ---------------------------------------------------------------
  // base tick and scaler chain
  // ---------------------------------------------------------------
  logic [7:0] base_r, base_nxt;
  logic base_tick_r, base_tick_nxt;
  logic [4:0] stage_tick;
  logic [3:0] f6_cnt_r, f6_cnt_nxt;
  logic f6_tick_r, f6_tick_nxt;
  logic [15:0] stage_div;
  logic src_tick;

  always_comb begin
    base_nxt = base_r + 8'h1;
    base_tick_nxt = 1'b0;
    if (base_r == 8'(BASE_DIV - 1)) begin
      base_nxt = 8'h0;
      base_tick_nxt = 1'b1;
    end
  end

  // one chain, shared division factor
  assign stage_div = global_mode_register_i[MODE_DEC_BIT] ? 16'(BCD_DIV) : 16'(BIN_DIV);

  scaler_stage u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(ce_i),
    .tick_i(base_tick_r),
    .div_i(prescaler_i),
    .tick_o(stage_tick[0])
  );

  genvar g;
  generate
    for (g = 1; g < 5; g++) begin : g_stage
      scaler_stage u_st (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(ce_i),
        .tick_i(stage_tick[g-1]),
        .div_i(stage_div),
        .tick_o(stage_tick[g])
      );
    end
  endgenerate

  always_comb begin
    // codes beyond four fall back to the prescaled clock
    case (global_mode_register_i[MODE_SRC_LO +: 4])
      4'h1: src_tick = stage_tick[1];
      4'h2: src_tick = stage_tick[2];
      4'h3: src_tick = stage_tick[3];
      4'h4: src_tick = stage_tick[4];
      default: src_tick = stage_tick[0];
    endcase
    f6_cnt_nxt = f6_cnt_r;
    f6_tick_nxt = 1'b0;
    if (src_tick) begin
      if (f6_cnt_r == global_mode_register_i[MODE_DIV5_LO +: 4]) begin
        f6_cnt_nxt = 4'h0;
        f6_tick_nxt = 1'b1;
      end else begin
        f6_cnt_nxt = f6_cnt_r + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // reference clock outputs: divided ticks stretched to square levels
  // ---------------------------------------------------------------
  logic [4:0] ref_nxt;
  logic f6_lvl_nxt;
  logic [NUM_GATES-1:0] gate_nxt;
  always_comb begin
    ref_nxt = ref_clk_o ^ stage_tick;
    f6_lvl_nxt = ref_clk_gate_select_o ^ f6_tick_r;
    gate_nxt = gate_sel_i & {NUM_GATES{f6_lvl_nxt}};
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_r <= 8'h0;
      base_tick_r <= 1'b0;
      f6_cnt_r <= 4'h0;
      f6_tick_r <= 1'b0;
      ref_clk_o <= 5'h0;
      ref_clk_gate_select_o <= 1'b0;
      gate_o <= '0;
    end else if (ce_i) begin
      base_r <= base_nxt;
      base_tick_r <= base_tick_nxt;
      f6_cnt_r <= f6_cnt_nxt;
      f6_tick_r <= f6_tick_nxt;
      ref_clk_o <= ref_nxt;
      ref_clk_gate_select_o <= f6_lvl_nxt;
      gate_o <= gate_nxt;
    end
  end

  // ---------------------------------------------------------------
  // comparators and output shaping
  // ---------------------------------------------------------------
  logic [NOUT-1:0] shaped;
  logic [NOUT-1:0] sample;
  logic out_en_r, out_en_nxt;
  logic [NOUT-1:0] out_nxt;
  logic [15:0] hold_cnt_r [NOUT];
  logic [15:0] hold_cnt_nxt [NOUT];
  logic busy_s1_r, busy_s2_r;
  logic [NOUT-1:0] out_q;

  // cyclic scan only while the command engine is idle
  assign sample[NUM_SW-1:0] = sw_cmp_en_i & {NUM_SW{stage_tick[0]}};
  assign sample[NOUT-1:NUM_SW] = cyc_cmp_en_i & {NUM_CYC{!busy_s2_r}};

  generate
    for (g = 0; g < NOUT; g++) begin : g_out
      if (g < NUM_SW) begin : g_sw
        out_shaper u_sh (
          .clk_i(clk_i),
          .rst_i(rst_i),
          .en_i(ce_i),
          .sample_i(sample[g]),
          .osel_i(sw_osel_i[g*3 +: 3]),
          .invert_i(sw_invert_i[g]),
          .count_i(sw_count_i[g*CNT_W +: CNT_W]),
          .threshold_i(sw_threshold_i[g*CNT_W +: CNT_W]),
          .pulse_len_i(pulse_duration_i),
          .pulse_tick_i(base_tick_r),
          .level_o(shaped[g])
        );
      end else begin : g_cyc
        out_shaper u_sh (
          .clk_i(clk_i),
          .rst_i(rst_i),
          .en_i(ce_i),
          .sample_i(sample[g]),
          .osel_i(cyc_osel_i[(g-NUM_SW)*3 +: 3]),
          .invert_i(1'b0),
          .count_i(cyc_count_i[(g-NUM_SW)*CNT_W +: CNT_W]),
          .threshold_i(cyc_threshold_i[(g-NUM_SW)*CNT_W +: CNT_W]),
          .pulse_len_i(pulse_duration_i),
          .pulse_tick_i(base_tick_r),
          .level_o(shaped[g])
        );
      end
    end
  endgenerate

  // output limiter: each pin holds a level at least half a 40 kHz period, except a high level that a disable drops
  always_comb begin
    out_en_nxt = out_en_r;
    if (output_disable_cmd_i) out_en_nxt = 1'b0;
    if (output_enable_cmd_i) out_en_nxt = 1'b1;
    for (int i = 0; i < NOUT; i++) begin
      hold_cnt_nxt[i] = hold_cnt_r[i];
      out_nxt[i] = out_q[i];
      // suppression outranks the hold so a disable never leaves a pin high
      if (!out_en_r && out_q[i]) begin
        out_nxt[i] = 1'b0;
        hold_cnt_nxt[i] = 16'(OUT_MIN_CYC - 1);
      end else if (hold_cnt_r[i] != 16'h0) begin
        hold_cnt_nxt[i] = hold_cnt_r[i] - 16'h1;
      end else if ((shaped[i] & out_en_r) != out_q[i]) begin
        out_nxt[i] = shaped[i] & out_en_r;
        hold_cnt_nxt[i] = 16'(OUT_MIN_CYC - 1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_en_r <= 1'b0;
      out_q <= '0;
      busy_s1_r <= 1'b1;
      busy_s2_r <= 1'b1;
      for (int i = 0; i < NOUT; i++) hold_cnt_r[i] <= 16'h0;
    end else if (ce_i) begin
      out_en_r <= out_en_nxt;
      out_q <= out_nxt;
      busy_s1_r <= busy_i;
      busy_s2_r <= busy_s1_r;
      for (int i = 0; i < NOUT; i++) hold_cnt_r[i] <= hold_cnt_nxt[i];
    end
  end
  assign out_o = out_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_OUT_OFF_UNTIL_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    !out_en_r |-> ##1 (out_q == '0)) else $error("output active before enable");
  AST_HOLD_40K: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && out_q[0] != $past(out_q[0])) |-> hold_cnt_r[0] == 16'(OUT_MIN_CYC - 1))
    else $error("output toggled faster than limit");
  AST_NO_SCAN_BUSY: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_s2_r |-> sample[NOUT-1:NUM_SW] == '0) else $error("scan while busy");
  AST_SCAN_NEEDS_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    !cyc_cmp_en_i[0] |-> !sample[NUM_SW]) else $error("scan without enable");
  AST_F6_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && f6_tick_r && global_mode_register_i[MODE_DIV5_LO +: 4] != 4'h0)
    |=> !f6_tick_r) else $error("sixth clock too fast");
  AST_GATE_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> gate_o == (gate_sel_i & {NUM_GATES{ref_clk_gate_select_o}}) || !$stable(gate_sel_i))
    else $error("gate not routed from sixth clock");
  AST_STAGE_CHAIN: assert property (@(posedge clk_i) disable iff (rst_i)
    stage_tick[1] |-> $past(stage_tick[0])) else $error("stage ticked without input");
  AST_REF_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && stage_tick[0]) |=> ref_clk_o[0] != $past(ref_clk_o[0]))
    else $error("reference clock one not toggled");
  AST_PRE_ON_BASE: assert property (@(posedge clk_i) disable iff (rst_i)
    stage_tick[0] |-> $past(base_tick_r)) else $error("prescaler ticked without base");
  AST_F6_FROM_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
    f6_tick_r |-> $past(src_tick)) else $error("sixth clock without source tick");
  AST_SCAN_WHEN_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!busy_s2_r && cyc_cmp_en_i[1]) |-> sample[NOUT-1]) else $error("idle scan missing");
  AST_HOLD_CYC: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && out_q[NUM_SW] != $past(out_q[NUM_SW])) |-> hold_cnt_r[NUM_SW] == 16'(OUT_MIN_CYC - 1))
    else $error("cyclic output toggled faster than limit");
  AST_HOLD_STEADY: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && out_en_r && hold_cnt_r[0] != 16'h0) |=> out_q[0] == $past(out_q[0]))
    else $error("output moved during hold");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  COV_ENABLE: cover property (@(posedge clk_i) disable iff (rst_i) $rose(out_en_r));
  COV_F6: cover property (@(posedge clk_i) disable iff (rst_i) f6_tick_r);
  COV_OUT_HIGH: cover property (@(posedge clk_i) disable iff (rst_i) $rose(out_q[NUM_SW]));
  COV_LOW_PULSE: cover property (@(posedge clk_i) disable iff (rst_i) $fell(out_q[NOUT-1]));
  COV_IDLE_AGAIN: cover property (@(posedge clk_i) disable iff (rst_i) $fell(busy_s2_r));
endmodule : counter_compare_refclock

// ### testbench/host_cfg_model.sv
`timescale 1ns/1ps
module host_cfg_model (
  input wire logic clk_i,
  input wire logic [15:0] pre_req_i,
  input wire logic [3:0] div_req_i,
  input wire logic [3:0] src_req_i,
  input wire logic dec_i,
  input wire logic [31:0] thr_req_i,
  output logic [15:0] prescaler_o,
  output logic [15:0] mode_o,
  output logic [31:0] thr_o
);
  // -------------------------
  // host side settings
  // -------------------------
  logic [3:0] div;
  // prescaler 1 with divide 1 would push the sixth clock past its limit
  assign div = (pre_req_i < 16'h2 && div_req_i == 4'h0) ? 4'h1 : div_req_i;
  always_ff @(posedge clk_i) begin
    prescaler_o <= (pre_req_i == 16'h0) ? 16'h1 : pre_req_i;
    mode_o <= {dec_i, 3'h0, div, src_req_i, 4'h0};
    // small positive nonzero value, far from the wrap point
    thr_o <= {8'h0, thr_req_i[23:0] | 24'h1};
  end
endmodule : host_cfg_model

// ### testbench/counter_compare_refclock_bench.sv
`timescale 1ns/1ps
module counter_compare_refclock_bench;
  import cmp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic busy_i = 1'b0;
  logic oe_cmd = 1'b0;
  logic dec = 1'b1;
  logic [3:0] div_req = 4'h1;
  logic [3:0] src_req = 4'h1;
  logic [15:0] pre_req = 16'h1;
  logic [31:0] thr_req = 32'h100;
  logic [NUM_SW-1:0] sw_inv = '0;
  logic [NUM_SW*3-1:0] sw_osel = '0;
  logic [NUM_SW*CNT_W-1:0] sw_cnt = '0;
  logic [NUM_CYC*3-1:0] cyc_osel = '0;
  logic [NUM_CYC*CNT_W-1:0] cyc_cnt = {32'h0, 32'h100};
  logic [NUM_CYC*CNT_W-1:0] cyc_thr = {32'h0, 32'h5};
  logic [4:0] gsel = 5'h15;
  logic [15:0] pre;
  logic [15:0] mode;
  logic [31:0] thr;
  logic [4:0] ref_clk;
  logic [4:0] gate;
  logic [4:0] out;
  logic ref6;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 60912;
  int cyc = 0;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end

  always #2.5 clk_i = ~clk_i;

  host_cfg_model cfg_u (.clk_i(clk_i), .pre_req_i(pre_req), .div_req_i(div_req),
    .src_req_i(src_req), .dec_i(dec), .thr_req_i(thr_req), .prescaler_o(pre),
    .mode_o(mode), .thr_o(thr));

  counter_compare_refclock dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .global_mode_register_i(mode), .prescaler_i(pre), .pulse_duration_i(16'hf),
    .output_enable_cmd_i(oe_cmd), .output_disable_cmd_i(1'b0), .busy_i(busy_i),
    .sw_cmp_en_i(3'h7), .sw_invert_i(sw_inv), .sw_osel_i(sw_osel), .sw_count_i(sw_cnt),
    .sw_threshold_i({3{thr}}), .cyc_cmp_en_i(2'h3), .cyc_osel_i(cyc_osel),
    .cyc_count_i(cyc_cnt), .cyc_threshold_i(cyc_thr), .gate_sel_i(gsel),
    .ref_clk_o(ref_clk), .ref_clk_gate_select_o(ref6), .gate_o(gate), .out_o(out));

  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // -------------------------
  // helpers and reference model
  // -------------------------
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 98000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  function automatic logic sig(input int k);
    return (k < 5) ? ref_clk[k] : ref6;
  endfunction : sig

  // half period in cycles; first toggle only aligns, stale divider counts are skipped
  task automatic period(input int k, input int reps, output int n);
    logic s;
    for (int r = 0; r < reps; r++) begin
      s = sig(k);
      n = 0;
      while (sig(k) === s && n < 40000) begin
        tick(1);
        n++;
      end
    end
  endtask : period

  task automatic set_ch(input int k, input logic [2:0] os, input logic inv,
    input logic [31:0] c, input logic [31:0] t);
    if (k < 3) begin
      sw_osel[k*3 +: 3] = os;
      sw_inv[k] = inv;
      sw_cnt[k*32 +: 32] = c;
    end else begin
      cyc_osel[(k-3)*3 +: 3] = os;
      cyc_cnt[(k-3)*32 +: 32] = c;
      cyc_thr[(k-3)*32 +: 32] = t;
    end
  endtask : set_ch

  function automatic logic mdl(input logic [2:0] os, input logic inv, input logic [31:0] c,
    input logic [31:0] t);
    case (os)
      OSEL_HIGH_GE: return inv ^ (t[31] ? $signed(c) <= $signed(t) : $signed(c) >= $signed(t));
      OSEL_HIGH_LT: return inv ^ (t[31] ? $signed(c) > $signed(t) : $signed(c) < $signed(t));
      OSEL_PULSE_LO: return ~inv;
      default: return inv;
    endcase
  endfunction : mdl

  // -------------------------
  // main sequence
  // -------------------------
  initial begin
    int n;
    int k;
    logic [2:0] os;
    logic inv;
    logic [31:0] t;
    logic [31:0] c;
    tick(10);
    rst_i = 1'b0;
    `CHK(out, 5'h0)
    tick(3000);
    `CHK(out, 5'h0)
    oe_cmd = 1'b1;
    tick(1);
    oe_cmd = 1'b0;
    period(0, 2, n);
    `CHK(n, BASE_DIV)
    period(1, 2, n);
    `CHK(n, BASE_DIV * BCD_DIV)
    period(5, 2, n);
    `CHK(n, BASE_DIV * BCD_DIV * 2)
    tick(3);
    `CHK(gate, {5{ref6}} & gsel)
    dec = 1'b0;
    src_req = 4'h0;
    div_req = 4'h3;
    period(1, 3, n);
    `CHK(n, BASE_DIV * BIN_DIV)
    period(5, 3, n);
    `CHK(n, BASE_DIV * 4)
    for (int i = 0; i < 8; i++) begin
      k = i % 5;
      os = (i < 4) ? OSEL_HIGH_GE : OSEL_HIGH_LT;
      inv = (k < 3) ? 1'($random(seed) & 1) : 1'b0;
      thr_req = $random(seed);
      tick(2);
      t = (k < 3) ? thr : $random(seed);
      c = t + 32'(($random(seed) & 3) - 1);
      set_ch(k, os, inv, c, t);
      tick(2800);
      `CHK(out[k], mdl(os, inv, c, t))
    end
    for (int j = 0; j < 2; j++) begin
      c = j ? 32'h80000000 : 32'h7fffffff;
      set_ch(3, OSEL_HIGH_GE, 1'b0, c, 32'h100);
      tick(2800);
      `CHK(out[3], mdl(OSEL_HIGH_GE, 1'b0, c, 32'h100))
    end
    set_ch(4, OSEL_HIGH_GE, 1'b0, 32'h10, 32'h20);
    tick(2800);
    busy_i = 1'b1;
    tick(4);
    set_ch(4, OSEL_HIGH_GE, 1'b0, 32'h30, 32'h20);
    tick(2800);
    `CHK(out[4], 1'b0)
    busy_i = 1'b0;
    tick(2800);
    `CHK(out[4], 1'b1)
    for (int j = 0; j < 3; j++) begin
      k = (j == 2) ? 0 : j + 3;
      os = (j == 1) ? OSEL_PULSE_LO : OSEL_PULSE_HI;
      t = (k < 3) ? thr : 32'h200;
      set_ch(k, os, 1'b0, t + 32'h5, t);
      tick(3000);
      `CHK(out[k], os == OSEL_PULSE_LO)
      set_ch(k, os, 1'b0, t, t);
      tick(1500);
      `CHK(out[k], os != OSEL_PULSE_LO)
      tick(3000);
      `CHK(out[k], os == OSEL_PULSE_LO)
      if (k > 2) begin
        set_ch(k, os, 1'b0, 32'h80000000, t);
        tick(3000);
        `CHK(out[k], os == OSEL_PULSE_LO)
      end
    end
    stop_test();
  end
endmodule : counter_compare_refclock_bench
